// *** verilog/snap_params.svh ***
`ifndef SNAP_PARAMS_SVH
`define SNAP_PARAMS_SVH
`define SNAP_ADDR_W        4
`define SNAP_OFS_CTRL_A    4'h0
`define SNAP_OFS_CTRL_B    4'h1
`define SNAP_OFS_PTR_A     4'h2
`define SNAP_OFS_PTR_B     4'h3
`define SNAP_OFS_DATA_A    4'h4
`define SNAP_OFS_DATA_B    4'h5
`define SNAP_OFS_LOWER     4'h6
`define SNAP_OFS_UPPER     4'h7
`define SNAP_OFS_SHIFT     4'h8
`define SNAP_OFS_BUDGET    4'h9
`define SNAP_OFS_STATUS    4'hA
`define SNAP_CTL_MODE_LSB  0
`define SNAP_CTL_TAP_LSB   2
`define SNAP_CTL_FUNC_LSB  5
`define SNAP_CTL_CLEAR_BIT 7
`define SNAP_MEM_WORDS     2048
`define SNAP_PTR_MAX       11'h7FF
`define SNAP_CAPTURE_LAST  10'h3FF
`define SNAP_FIFO_DEPTH    16
`endif

// *** verilog/snap_pkg.sv ***
package snap_pkg;
    typedef enum logic [1:0] {MODE_OFF, MODE_CAPTURE, MODE_HIST} mode_type;
    typedef enum logic [1:0] {FN_I, FN_Q, FN_MAG} func_type;
endpackage

// *** verilog/snap_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module snap_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input  wire logic             I_CLK,
    input  wire logic             I_RSTN,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    wire              full  = (wp_q[AW] != rp_q[AW]) &&
                              (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire              empty = (wp_q == rp_q);
    wire              push  = i_valid && !full;
    wire              pop   = !empty && i_ready;

    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rp_q[AW-1:0]];

    always_ff @(posedge I_CLK) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + (AW+1)'(1);
            end
            if (pop) begin
                rp_q <= rp_q + (AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/snap_monitor.sv ***
// Notes on behaviour
// R1 - two identical monitoring memories, each configured on its own; the code shares the lower, upper and shift registers.
// R2 - each memory is off, capturing, or building a histogram.
// R3 - capture uses 2K 16-bit words, I and Q interleaved.
// R4 - histogram counters are 32 bits, upper half even, lower half odd.
// R5 - each memory picks the input tap or one of four stage outputs.
// R6 - capture stores I[17:2] at 2n and Q[17:2] at 2n+1.
// R7 - histogram function is I, Q or I*I+Q*Q.
// R8 - magnitude squared keeps only its upper 16 bits.
// R9 - values outside lower..upper limit change no bin.
// R10 - bin index is (value - lower limit) shifted right by the shift.
// R11 - host keeps limits signed 16-bit and index within 0..1023.
// R12 - a control bit clears one whole memory to zero.
// R13 - host clears a memory before histogram accumulation.
// R14 - pointer advances after each data port access.
// R15 - pointer wraps to zero past 2047.
// R16 - each accepted sample adds one to its 32-bit bin coherently.
// R17 - capture stops after 1024 complex samples.
`include "snap_params.svh"
`timescale 1ns/100ps
`default_nettype none
module snap_monitor #(
    parameter int SAMPLE_W = 18
) (
    input  wire logic                    I_CLK,
    input  wire logic                    I_RSTN,
    input  wire logic [5*SAMPLE_W-1:0]   I_TAP_I,
    input  wire logic [5*SAMPLE_W-1:0]   I_TAP_Q,
    input  wire logic                    I_SAMPLE_VALID,
    input  wire logic [`SNAP_ADDR_W-1:0] I_ADDR,
    input  wire logic [15:0]             I_WDATA,
    input  wire logic                    I_WR,
    input  wire logic                    I_RD,
    output logic      [15:0]             O_RDATA,
    output logic                         O_BACKPRESSURE
);
    localparam int FW = 2 * SAMPLE_W;

    logic signed [15:0] lower_q;
    logic signed [15:0] upper_q;
    logic        [3:0]  shift_q;
    logic        [15:0] budget_q;
    logic        [15:0] rdata_q;
    logic        [15:0] rdata_d;
    logic        [1:0]  ovf_q;

    function automatic logic [10:0] ptr_next(input logic [10:0] p);
        ptr_next = (p == `SNAP_PTR_MAX) ? 11'h000 : p + 11'h001; // R15
    endfunction

    function automatic logic signed [15:0] hist_fn(
        input snap_pkg::func_type f,
        input logic signed [SAMPLE_W-1:0] si,
        input logic signed [SAMPLE_W-1:0] sq);
        logic signed [2*SAMPLE_W:0] mag;
        mag = 37'(si * si) + 37'(sq * sq);
        case (f)
            snap_pkg::FN_I: hist_fn = si[SAMPLE_W-1 -: 16]; // R7
            snap_pkg::FN_Q: hist_fn = sq[SAMPLE_W-1 -: 16]; // R7
            // full 18-bit operands are squared; bits 33:18 of the sum are kept
            default: hist_fn = mag[2*SAMPLE_W-3 -: 16]; // R8
        endcase
    endfunction

    // shared registers, one pair of memory units
    wire w_lower  = I_WR && I_ADDR == `SNAP_OFS_LOWER;
    wire w_upper  = I_WR && I_ADDR == `SNAP_OFS_UPPER;
    wire w_shift  = I_WR && I_ADDR == `SNAP_OFS_SHIFT;
    wire w_budget = I_WR && I_ADDR == `SNAP_OFS_BUDGET;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            lower_q  <= 16'sh0000;
            upper_q  <= 16'sh7FFF;
            shift_q  <= 4'h0;
            budget_q <= 16'h0000;
        end else begin
            if (w_lower) begin
                lower_q <= I_WDATA;
            end
            if (w_upper) begin
                upper_q <= I_WDATA;
            end
            if (w_shift) begin
                shift_q <= I_WDATA[3:0];
            end
            if (w_budget) begin
                budget_q <= I_WDATA;
            end
        end
    end

    logic [15:0] unit_rd [2];
    logic [15:0] unit_ctl [2];
    logic [10:0] unit_ptr [2];
    logic [1:0]  unit_busy;
    logic [1:0]  unit_ready;

    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_unit // R1
            localparam logic [3:0] OC =
                u ? `SNAP_OFS_CTRL_B : `SNAP_OFS_CTRL_A;
            localparam logic [3:0] OP = u ? `SNAP_OFS_PTR_B : `SNAP_OFS_PTR_A;
            localparam logic [3:0] OD =
                u ? `SNAP_OFS_DATA_B : `SNAP_OFS_DATA_A;
            logic [15:0] mem [`SNAP_MEM_WORDS]; // R3
            logic [7:0]  ctl_q;
            logic [10:0] ptr_q;
            logic [10:0] clr_q;
            logic        clearing_q;
            logic [9:0]  cap_q;
            logic        cap_done_q;
            logic [15:0] rd_q;
            // histogram pipeline: read upper, write upper, write lower
            logic [1:0]  hp_q;
            logic [9:0]  bin_q;
            logic [15:0] hi_q;
            logic [31:0] sum;
            logic        cap_odd_q;
            logic [15:0] cap_qw_q;
            logic [9:0]  cap_n_q;

            wire snap_pkg::mode_type mode = snap_pkg::mode_type'(
                ctl_q[`SNAP_CTL_MODE_LSB +: 2]); // R2
            wire [2:0] tap = ctl_q[`SNAP_CTL_TAP_LSB +: 3];
            wire snap_pkg::func_type fn = snap_pkg::func_type'(
                ctl_q[`SNAP_CTL_FUNC_LSB +: 2]);
            wire w_ctl = I_WR && I_ADDR == OC;
            wire w_ptr = I_WR && I_ADDR == OP;
            wire acc_d = (I_WR || I_RD) && I_ADDR == OD;
            wire [2:0] tsel = (tap > 3'd4) ? 3'd4 : tap;
            wire signed [SAMPLE_W-1:0] si =
                I_TAP_I[tsel*SAMPLE_W +: SAMPLE_W]; // R5
            wire signed [SAMPLE_W-1:0] sq =
                I_TAP_Q[tsel*SAMPLE_W +: SAMPLE_W]; // R5

            // sample FIFO decouples the stream from the 3-cycle bin update
            logic [FW-1:0] f_data;
            logic          f_valid;
            logic          f_ready;
            wire           pipe_free = hp_q == 2'd0 && !clearing_q &&
                                       !cap_odd_q && !acc_d;
            snap_fifo #(.WIDTH(FW), .DEPTH(`SNAP_FIFO_DEPTH)) u_fifo (
                .I_CLK  (I_CLK),
                .I_RSTN (I_RSTN),
                .i_data ({si, sq}),
                .i_valid(I_SAMPLE_VALID && mode != snap_pkg::MODE_OFF),
                .o_ready(unit_ready[u]),
                .o_data (f_data),
                .o_valid(f_valid),
                .i_ready(f_ready)
            );
            assign f_ready = pipe_free;

            wire signed [SAMPLE_W-1:0] fi = f_data[FW-1 -: SAMPLE_W];
            wire signed [SAMPLE_W-1:0] fq = f_data[SAMPLE_W-1:0];
            wire signed [15:0] fv = hist_fn(fn, fi, fq);
            wire in_rng = fv >= lower_q && fv <= upper_q; // R9
            wire [16:0] diff = 17'(fv) - 17'(lower_q);
            wire [9:0] bin = 10'(diff >> shift_q); // R10
            wire take = f_valid && pipe_free;
            wire do_cap = take && mode == snap_pkg::MODE_CAPTURE && !cap_done_q;
            wire do_hist = take && mode == snap_pkg::MODE_HIST && in_rng;

            assign sum = {hi_q, mem[{bin_q, 1'b1}]} + 32'h0000_0001; // R16

            always_ff @(posedge I_CLK) begin
                if (clearing_q) begin
                    mem[clr_q] <= 16'h0000; // R12
                end else if (do_cap) begin
                    mem[{cap_n_q, 1'b0}] <= fi[SAMPLE_W-1 -: 16]; // R6
                end else if (cap_odd_q) begin
                    mem[{cap_n_q, 1'b1}] <= cap_qw_q; // R6
                end else if (hp_q == 2'd2) begin
                    mem[{bin_q, 1'b0}] <= sum[31:16]; // R4
                end else if (hp_q == 2'd3) begin
                    mem[{bin_q, 1'b1}] <= sum[15:0]; // R4
                end else if (I_WR && I_ADDR == OD) begin
                    mem[ptr_q] <= I_WDATA;
                end
            end

            always_ff @(posedge I_CLK or negedge I_RSTN) begin
                if (!I_RSTN) begin
                    ctl_q      <= 8'h00;
                    ptr_q      <= 11'h000;
                    clr_q      <= 11'h000;
                    clearing_q <= 1'b0;
                    cap_done_q <= 1'b0;
                    cap_odd_q  <= 1'b0;
                    cap_qw_q   <= 16'h0000;
                    cap_n_q    <= 10'h000;
                    hp_q       <= 2'd0;
                    bin_q      <= 10'h000;
                    hi_q       <= 16'h0000;
                    rd_q       <= 16'h0000;
                end else begin
                    if (w_ctl) begin
                        ctl_q <= I_WDATA[7:0];
                        cap_n_q <= 10'h000;
                        cap_done_q <= 1'b0;
                        if (I_WDATA[`SNAP_CTL_CLEAR_BIT]) begin
                            clearing_q <= 1'b1; // R12
                            clr_q <= 11'h000;
                        end
                    end else if (clearing_q) begin
                        clr_q <= clr_q + 11'h001;
                        if (clr_q == `SNAP_PTR_MAX) begin
                            clearing_q <= 1'b0;
                            ctl_q[`SNAP_CTL_CLEAR_BIT] <= 1'b0;
                        end
                    end
                    if (w_ptr) begin
                        ptr_q <= I_WDATA[10:0];
                    end else if (acc_d) begin
                        ptr_q <= ptr_next(ptr_q); // R14
                    end
                    if (I_RD && I_ADDR == OD) begin
                        rd_q <= mem[ptr_q];
                    end
                    cap_odd_q <= do_cap;
                    if (do_cap) begin
                        cap_qw_q <= fq[SAMPLE_W-1 -: 16];
                    end
                    if (cap_odd_q) begin
                        cap_n_q <= cap_n_q + 10'h001;
                        if (cap_n_q == `SNAP_CAPTURE_LAST) begin
                            cap_done_q <= 1'b1; // R17
                        end
                    end
                    case (hp_q)
                        2'd0: if (do_hist) begin
                            bin_q <= bin;
                            hp_q  <= 2'd1;
                        end
                        2'd1: begin
                            hi_q <= mem[{bin_q, 1'b0}];
                            hp_q <= 2'd2;
                        end
                        2'd2: hp_q <= 2'd3;
                        default: hp_q <= 2'd0;
                    endcase
                end
            end
            assign unit_rd[u]   = rd_q;
            assign unit_ctl[u]  = {8'h00, ctl_q};
            assign unit_ptr[u]  = ptr_q;
            assign unit_busy[u] = clearing_q || (mode ==
                snap_pkg::MODE_CAPTURE && !cap_done_q);
        end
    endgenerate

    assign O_BACKPRESSURE = !(&unit_ready);

    always_comb begin
        rdata_d = 16'h0000;
        case (I_ADDR)
            `SNAP_OFS_CTRL_A: rdata_d = unit_ctl[0];
            `SNAP_OFS_CTRL_B: rdata_d = unit_ctl[1];
            `SNAP_OFS_PTR_A:  rdata_d = {5'h00, unit_ptr[0]};
            `SNAP_OFS_PTR_B:  rdata_d = {5'h00, unit_ptr[1]};
            `SNAP_OFS_LOWER:  rdata_d = lower_q;
            `SNAP_OFS_UPPER:  rdata_d = upper_q;
            `SNAP_OFS_SHIFT:  rdata_d = {12'h000, shift_q};
            `SNAP_OFS_BUDGET: rdata_d = budget_q;
            `SNAP_OFS_STATUS: rdata_d = {12'h000, ovf_q, unit_busy};
            default:          rdata_d = 16'h0000;
        endcase
    end

    logic rd_mem_q;
    logic rd_sel_q;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdata_q  <= 16'h0000;
            rd_mem_q <= 1'b0;
            rd_sel_q <= 1'b0;
            ovf_q    <= 2'b00;
        end else begin
            rd_mem_q <= I_RD && (I_ADDR == `SNAP_OFS_DATA_A ||
                                 I_ADDR == `SNAP_OFS_DATA_B);
            rd_sel_q <= I_ADDR == `SNAP_OFS_DATA_B;
            ovf_q    <= ~unit_ready;
            if (I_RD) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign O_RDATA = rd_mem_q ? unit_rd[rd_sel_q] : rdata_q;

    property p_ptr_inc;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (I_RD && I_ADDR == `SNAP_OFS_DATA_A &&
         g_unit[0].ptr_q != `SNAP_PTR_MAX)
        |=> g_unit[0].ptr_q == $past(g_unit[0].ptr_q) + 11'h001;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("no step"); // R14
    property p_ptr_wrap;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (I_RD && I_ADDR == `SNAP_OFS_DATA_B &&
         g_unit[1].ptr_q == `SNAP_PTR_MAX)
        |=> g_unit[1].ptr_q == 11'h000;
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("no wrap"); // R15
    property p_cap_stop;
        @(posedge I_CLK) disable iff (!I_RSTN)
        g_unit[0].cap_done_q && !g_unit[0].w_ctl |=> !g_unit[0].cap_odd_q;
    endproperty
    a_cap_stop: assert property (p_cap_stop) else $error("ran on"); // R17
    sequence s_clear_start;
        g_unit[0].w_ctl && I_WDATA[`SNAP_CTL_CLEAR_BIT];
    endsequence
    property p_clear;
        @(posedge I_CLK) disable iff (!I_RSTN)
        s_clear_start |=> g_unit[0].clearing_q [*8];
    endproperty
    a_clear: assert property (p_clear) else $error("clear too short"); // R12
    property p_hist_seq;
        @(posedge I_CLK) disable iff (!I_RSTN)
        g_unit[0].do_hist |=> g_unit[0].hp_q == 2'd1 ##1 g_unit[0].hp_q == 2'd2
        ##1 g_unit[0].hp_q == 2'd3;
    endproperty
    a_hist_seq: assert property (p_hist_seq) else $error("bin update"); // R16
    property p_range;
        @(posedge I_CLK) disable iff (!I_RSTN)
        g_unit[0].take && g_unit[0].mode == snap_pkg::MODE_HIST &&
        (g_unit[0].fv < lower_q || g_unit[0].fv > upper_q)
        |=> g_unit[0].hp_q == 2'd0;
    endproperty
    a_range: assert property (p_range) else $error("out of range"); // R9
    property p_off;
        @(posedge I_CLK) disable iff (!I_RSTN)
        // an idle unit must not queue samples from the stream
        g_unit[1].mode == snap_pkg::MODE_OFF && !g_unit[1].w_ctl &&
        !g_unit[1].f_valid |=> !g_unit[1].f_valid;
    endproperty
    a_off: assert property (p_off) else $error("off unit active"); // R2
    property p_cap_pair;
        @(posedge I_CLK) disable iff (!I_RSTN)
        g_unit[1].do_cap |=> g_unit[1].cap_odd_q ##1 !g_unit[1].cap_odd_q;
    endproperty
    a_cap_pair: assert property (p_cap_pair) else $error("pair broken"); // R6
endmodule
`default_nettype wire

// *** sim/sample_source.sv ***
`timescale 1ns/100ps
`default_nettype none
module sample_source (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_start,
    input  wire logic [11:0] i_count,
    input  wire logic [3:0]  i_gap,
    output logic      [89:0] o_tap_i,
    output logic      [89:0] o_tap_q,
    output logic             o_valid,
    output logic             o_busy
);
    logic [11:0] n_q;
    logic [11:0] cur_q;
    logic [3:0]  gap_q;
    logic        flip_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            n_q     <= 12'h000;
            cur_q   <= 12'h000;
            gap_q   <= 4'h0;
            flip_q  <= 1'b0;
            o_valid <= 1'b0;
            o_busy  <= 1'b0;
        end else begin
            flip_q  <= ~flip_q;
            o_valid <= 1'b0;
            if (i_start) begin
                n_q    <= 12'h000;
                gap_q  <= 4'h0;
                o_busy <= 1'b1;
            end else if (o_busy && gap_q != 4'h0) begin
                gap_q <= gap_q - 4'h1;
            end else if (o_busy) begin
                o_valid <= 1'b1;
                cur_q   <= n_q;
                n_q     <= n_q + 12'h001;
                gap_q   <= i_gap;
                o_busy  <= (n_q != i_count - 12'h001);
            end
        end
    end

    // idle cycles toggle so a stale sample can never pass for a fresh one
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            o_tap_i[k*18 +: 18] = o_valid ? {1'b0, 3'(k), cur_q, 2'h3}
                                          : {18{flip_q}};
            o_tap_q[k*18 +: 18] = o_valid ? ~{1'b0, 3'(k), cur_q, 2'h3}
                                          : {18{~flip_q}};
        end
    end
endmodule
`default_nettype wire

// *** sim/test_snap_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "snap_params.svh"
module test_snap_monitor;
    logic        clk = 1'b0;
    logic        rstn;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic [15:0] rdata;
    logic [15:0] rd_v;
    logic [89:0] tap_i;
    logic [89:0] tap_q;
    logic        svalid;
    logic        src_start;
    logic [11:0] src_count;
    logic [3:0]  src_gap;
    logic        src_busy;
    logic        bp;
    logic        bp_seen;
    logic [31:0] exp_cnt [48];
    int          bad_count = 0;
    int          total_checks = 0;

    always #25 clk = ~clk;

    sample_source src (.i_clk(clk), .i_rstn(rstn), .i_start(src_start),
        .i_count(src_count), .i_gap(src_gap), .o_tap_i(tap_i),
        .o_tap_q(tap_q), .o_valid(svalid), .o_busy(src_busy));

    snap_monitor dut (.I_CLK(clk), .I_RSTN(rstn), .I_TAP_I(tap_i),
        .I_TAP_Q(tap_q), .I_SAMPLE_VALID(svalid), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
        .O_BACKPRESSURE(bp));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] fval(snap_pkg::func_type f,
                                         logic [2:0] k, logic [11:0] n);
        logic signed [17:0] si;
        logic signed [17:0] sq;
        logic signed [35:0] m;
        si = {1'b0, k, n, 2'h3};
        sq = ~si;
        m = si * si + sq * sq;
        case (f)
            snap_pkg::FN_I: return si[17:2];
            snap_pkg::FN_Q: return sq[17:2];
            default: return m[33:18];
        endcase
    endfunction

    function automatic logic [15:0] ctl(snap_pkg::mode_type m,
                                        logic [2:0] tap, snap_pkg::func_type f);
        return {9'h000, f, tap, m};
    endfunction

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
                          input string what);
        rd(a, rd_v);
        chk(what, {16'h0000, e}, {16'h0000, rd_v});
    endtask

    task automatic run_src(input logic [11:0] cnt, input logic [3:0] gap);
        src_count <= cnt;
        src_gap   <= gap;
        src_start <= 1'b1;
        @(posedge clk);
        src_start <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 20000 && src_busy; i++) begin
            @(posedge clk);
            bp_seen = bp_seen | bp;
        end
        if (src_busy !== 1'b0) begin
            chk("source finish", 32'h0, {31'h0, src_busy});
            wrap_up;
        end
        // fifo plus three-cycle bin update need time to settle
        repeat (200) @(posedge clk);
    endtask

    task automatic run_hist(input snap_pkg::func_type f, input logic [2:0] k,
                            input logic [15:0] lo, input logic [15:0] hi,
                            input logic [15:0] sh);
        logic [15:0] v;
        logic [15:0] idx;
        logic [15:0] hw;
        logic [15:0] lw;
        wr(`SNAP_OFS_CTRL_A, 16'h0080);
        repeat (2100) @(posedge clk);
        wr(`SNAP_OFS_LOWER, lo);
        wr(`SNAP_OFS_UPPER, hi);
        wr(`SNAP_OFS_SHIFT, sh);
        wr(`SNAP_OFS_CTRL_A, ctl(snap_pkg::MODE_HIST, k, f));
        for (int b = 0; b < 48; b++) exp_cnt[b] = 32'h0000_0000;
        for (int n = 0; n < 40; n++) begin
            v = fval(f, k, 12'(n));
            if ($signed(v) >= $signed(lo) && $signed(v) <= $signed(hi)) begin
                idx = (v - lo) >> sh[3:0];
                if (idx < 16'h0030) exp_cnt[idx] = exp_cnt[idx] + 32'h1;
            end
        end
        run_src(12'h028, 4'h7);
        wr(`SNAP_OFS_PTR_A, 16'h0000);
        for (int b = 0; b < 48; b++) begin
            rd(`SNAP_OFS_DATA_A, hw);
            rd(`SNAP_OFS_DATA_A, lw);
            chk("hist bin", exp_cnt[b], {hw, lw});
        end
    endtask

    initial begin
        logic [2:0] t;
        logic [3:0] po;
        logic [3:0] dof;
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        src_start = 1'b0;
        src_count = 12'h000;
        src_gap = 4'h0;
        bp_seen = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 16; a++) begin
            if (a != 4 && a != 5) begin
                rd_chk(4'(a), a == 7 ? 16'h7FFF : 16'h0000, "reset value");
            end
        end
        wr(4'hC, 16'hA5A5);
        rd_chk(4'hC, 16'h0000, "unmapped index");
        wr(`SNAP_OFS_PTR_A, 16'h0005);
        wr(`SNAP_OFS_DATA_A, 16'h1234);
        rd_chk(`SNAP_OFS_PTR_A, 16'h0006, "pointer after write");
        wr(`SNAP_OFS_PTR_A, 16'h0005);
        rd_chk(`SNAP_OFS_DATA_A, 16'h1234, "data word");
        rd_chk(`SNAP_OFS_PTR_A, 16'h0006, "pointer after read");
        // tap code above four falls back to the last stage
        wr(`SNAP_OFS_CTRL_A, ctl(snap_pkg::MODE_CAPTURE, 3'h2, snap_pkg::FN_I));
        wr(`SNAP_OFS_CTRL_B, ctl(snap_pkg::MODE_CAPTURE, 3'h7, snap_pkg::FN_I));
        run_src(12'h44C, 4'h3);
        for (int u = 0; u < 2; u++) begin
            t = (u == 0) ? 3'h2 : 3'h4;
            po = (u == 0) ? `SNAP_OFS_PTR_A : `SNAP_OFS_PTR_B;
            dof = (u == 0) ? `SNAP_OFS_DATA_A : `SNAP_OFS_DATA_B;
            wr(po, 16'h0000);
            for (int n = 0; n < 2; n++) begin
                rd_chk(dof, fval(snap_pkg::FN_I, t, 12'(n)), "capture I");
                rd_chk(dof, fval(snap_pkg::FN_Q, t, 12'(n)), "capture Q");
            end
            wr(po, 16'h07FE);
            rd_chk(dof, fval(snap_pkg::FN_I, t, 12'h3FF), "last I");
            rd_chk(dof, fval(snap_pkg::FN_Q, t, 12'h3FF), "last Q");
            rd_chk(po, 16'h0000, "pointer wrap");
            rd_chk(dof, fval(snap_pkg::FN_I, t, 12'h000), "word 0");
        end
        run_hist(snap_pkg::FN_I, 3'h0, 16'h0005, 16'h0014, 16'h0001);
        run_hist(snap_pkg::FN_Q, 3'h3, 16'hCFEC, 16'hCFFB, 16'h0001);
        run_hist(snap_pkg::FN_MAG, 3'h1, 16'h0800, 16'h7FFF, 16'h0000);
        // unit B idle, unit A left in histogram mode for a dense burst
        wr(`SNAP_OFS_CTRL_B, 16'h0000);
        chk("backpressure idle", 32'h0, {31'h0, bp_seen});
        run_src(12'h028, 4'h0);
        chk("backpressure", 32'h1, {31'h0, bp_seen});
        wrap_up;
    end
endmodule
`default_nettype wire
